/* File: core/storage_switch_control.sv */
/*
 * storage and power switch control: aux supply / aux ground switches,
 * converter force-off, supply sleep request and primary-cell store linking.
 * assumes a serial front end that issues single-cycle byte reads/writes,
 * analog comparators giving levels, and an external sleep timer.
 */
// Function
// - ground auto disconnect outside minimum-to-max window
// - converter-disable bit holds boost converter off
// - ground enable closes switch above minimum-high
// - supply enable connects output above minimum-high
// - sleep request disconnects main supply for interval
// - primary-cell mode: converter never charges long store
// - primary-cell: auto link stores when harvest short
// - harvester-low connects stores in primary-cell mode
// - low store measurement confirmed after 1 ms
// - auto link held two harvester periods
// - battery below minimum-low keeps stores apart
// - force-connect links stores in primary-cell mode, stops harvesting
// - store protection makes force-connect ineffective
// - protection-disable turns protection off, status zero
// - supply field picks one of four behaviours
`timescale 1ns/100ps
module storage_switch_control
   import switch_ctrl_pkg::*;
#(
   parameter int CONFIRM_COUNT = CONFIRM_CYCLES
) (
   // clock and reset
   input  wire logic                    sys_clk_in,
   input  wire logic                    srst_in,
   // register access from the serial front end
   input  wire logic [7:0]              reg_addr_in,
   input  wire logic [7:0]              reg_wdata_in,
   input  wire logic                    reg_wr_in,
   output logic      [7:0]              reg_rdata_out,
   // nonvolatile defaults
   input  wire logic [7:0]              nvm_storage_cell_in,
   input  wire logic [7:0]              nvm_aux_supply_in,
   input  wire logic [7:0]              nvm_aux_ground_in,
   input  wire logic [7:0]              nvm_power_switch_in,
   // comparator levels and measurement events
   input  wire logic                    sts_above_min_hi_in,
   input  wire logic                    sts_above_min_in,
   input  wire logic                    sts_below_apl_max_in,
   input  wire logic                    sts_below_disconnect_in,
   input  wire logic                    bat_below_min_lo_in,
   input  wire logic                    harvester_low_in,
   input  wire logic                    sts_meas_done_in,
   input  wire logic                    hrv_period_in,
   input  wire logic                    sleep_done_in,
   // switch drivers
   output logic [AUX_CHANNELS-1:0]      aux_ground_close_out,
   output logic [AUX_CHANNELS-1:0]      aux_to_store_out,
   output logic [AUX_CHANNELS-1:0]      aux_to_ldo_out,
   output logic [AUX_CHANNELS-1:0]      aux_grounded_out,
   output logic                         dcdc_force_off_out,
   output logic                         lts_charge_en_out,
   output logic                         stores_connect_out,
   output logic                         sleep_request_out,
   output logic                         lts_protect_out
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [CELL_FIELD_WIDTH-1:0]       cell_cfg_q;
   logic [2*AUX_CHANNELS-1:0]         aux_behav_q;
   logic [AUX_CHANNELS-1:0]           gnd_auto_q;
   logic [7:0]                        pwr_en_q;
   logic                              nvm_load_q;
   logic                              wr_cell;
   logic                              wr_aux;
   logic                              wr_gnd;
   logic                              wr_pwr;

   assign wr_cell = reg_wr_in && (reg_addr_in == STORAGE_CELL_CONFIG_ADDR);
   assign wr_aux  = reg_wr_in && (reg_addr_in == AUX_SUPPLY_CONFIG_ADDR);
   assign wr_gnd  = reg_wr_in && (reg_addr_in == AUX_GROUND_CONFIG_ADDR);
   assign wr_pwr  = reg_wr_in && (reg_addr_in == POWER_SWITCH_ENABLE_ADDR);

   // defaults arrive one edge after reset is released
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         nvm_load_q <= 1'b1;
      end else begin
         nvm_load_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cell_cfg_q  <= REG_RESET_VALUE[CELL_FIELD_WIDTH-1:0];
         aux_behav_q <= REG_RESET_VALUE[2*AUX_CHANNELS-1:0];
         gnd_auto_q  <= REG_RESET_VALUE[AUX_CHANNELS-1:0];
      end else if (nvm_load_q) begin
         cell_cfg_q  <= nvm_storage_cell_in[CELL_FIELD_WIDTH-1:0];
         aux_behav_q <= nvm_aux_supply_in[2*AUX_CHANNELS-1:0];
         gnd_auto_q  <= nvm_aux_ground_in[AUX_CHANNELS-1:0];
      end else begin
         if (wr_cell) cell_cfg_q  <= reg_wdata_in[CELL_FIELD_WIDTH-1:0];
         if (wr_aux)  aux_behav_q <= reg_wdata_in[2*AUX_CHANNELS-1:0];
         if (wr_gnd)  gnd_auto_q  <= reg_wdata_in[AUX_CHANNELS-1:0];
      end
   end

   // the sleep bit self-clears when the timer ends; a write of one wins
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pwr_en_q <= REG_RESET_VALUE;
      end else if (nvm_load_q) begin
         pwr_en_q <= nvm_power_switch_in;
      end else if (wr_pwr) begin
         pwr_en_q <= reg_wdata_in;
      end else if (sleep_done_in) begin
         pwr_en_q[PWR_SLEEP_BIT] <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // comparator synchronisers
   // ------------------------------------------------------------------
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] cmp_raw;
   logic [NSYNC-1:0] cmp_meta_q;
   logic [NSYNC-1:0] cmp_q;

   assign cmp_raw = {harvester_low_in, bat_below_min_lo_in, sts_below_disconnect_in,
                     sts_below_apl_max_in, sts_above_min_in, sts_above_min_hi_in};

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cmp_meta_q <= '0;
         cmp_q      <= '0;
      end else begin
         cmp_meta_q <= cmp_raw;
         cmp_q      <= cmp_meta_q;
      end
   end

   logic above_min_hi;
   logic above_min;
   logic below_apl_max;
   logic below_disc;
   logic bat_low;
   logic hrv_low;

   assign {hrv_low, bat_low, below_disc, below_apl_max, above_min, above_min_hi} = cmp_q;

   // ------------------------------------------------------------------
   // protection and mode decode
   // ------------------------------------------------------------------
   logic primary;
   logic protect;
   logic force_link;

   assign primary    = cell_cfg_q[CELL_PRIMARY_BIT];
   assign protect    = bat_low && !cell_cfg_q[CELL_NO_PROTECT_BIT];
   assign force_link = primary && cell_cfg_q[CELL_FORCE_CONN_BIT] && !protect;

   // ------------------------------------------------------------------
   // automatic store link in primary-cell mode
   // ------------------------------------------------------------------
   link_state_t state_q;
   link_state_t state_d;
   logic [$clog2(CONFIRM_COUNT+1)-1:0] confirm_cnt_q;
   logic [1:0]                         hold_cnt_q;
   logic                               confirm_end;
   logic                               hold_end;
   logic                               link_now;

   assign confirm_end = (confirm_cnt_q == '0);
   assign hold_end    = hrv_period_in && (hold_cnt_q == 2'(HOLD_HRV_PERIODS - 1));
   assign link_now    = hrv_low || (state_q == LINK_CONFIRM && confirm_end && below_disc);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         LINK_IDLE: begin
            if (hrv_low) begin
               state_d = LINK_HOLD;
            end else if (sts_meas_done_in && below_disc) begin
               state_d = LINK_CONFIRM;
            end
         end
         LINK_CONFIRM: begin
            if (link_now) begin
               state_d = LINK_HOLD;
            end else if (confirm_end) begin
               state_d = LINK_IDLE;
            end
         end
         LINK_HOLD: begin
            // re-evaluated only after the hold runs out
            if (hold_end) begin
               state_d = hrv_low ? LINK_HOLD : LINK_IDLE;
            end
         end
         default: state_d = LINK_IDLE;
      endcase
      if (!primary || protect) begin
         state_d = LINK_IDLE;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_q <= LINK_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // second measurement taken one confirm interval after the first
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         confirm_cnt_q <= '0;
      end else if (state_q == LINK_IDLE && state_d == LINK_CONFIRM) begin
         confirm_cnt_q <= ($bits(confirm_cnt_q))'(CONFIRM_COUNT - 1);
      end else if (state_q == LINK_CONFIRM && !confirm_end) begin
         confirm_cnt_q <= confirm_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         hold_cnt_q <= '0;
      end else if (state_q != LINK_HOLD || hold_end) begin
         hold_cnt_q <= '0;
      end else if (hrv_period_in) begin
         hold_cnt_q <= hold_cnt_q + 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // switch drivers, all registered
   // ------------------------------------------------------------------
   logic in_window;
   assign in_window = above_min && below_apl_max;

   generate
      for (genvar i = 0; i < AUX_CHANNELS; i++) begin : g_aux
         logic [1:0] behav;
         logic       sup_on;
         assign behav  = aux_behav_q[AUX_BEHAV_WIDTH*i +: AUX_BEHAV_WIDTH];
         // auto modes additionally drop out below store minimum
         assign sup_on = pwr_en_q[PWR_SUPPLY_EN_LSB+i] && above_min_hi &&
                         (behav[1] == 1'b0 || above_min);

         always_ff @(posedge sys_clk_in) begin
            if (srst_in) begin
               aux_ground_close_out[i] <= 1'b0;
               aux_to_store_out[i]     <= 1'b0;
               aux_to_ldo_out[i]       <= 1'b0;
               aux_grounded_out[i]     <= 1'b0;
            end else begin
               aux_ground_close_out[i] <= pwr_en_q[PWR_GROUND_EN_LSB+i] && above_min_hi &&
                                          !(gnd_auto_q[GND_AUTO_LSB+i] && !in_window);
               aux_to_store_out[i]     <= sup_on && behav != AUX_ON_LDO;
               aux_to_ldo_out[i]       <= sup_on && behav == AUX_ON_LDO;
               aux_grounded_out[i]     <= !sup_on && behav == AUX_AUTO_GROUND;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         dcdc_force_off_out <= 1'b0;
         lts_charge_en_out  <= 1'b0;
         stores_connect_out <= 1'b0;
         sleep_request_out  <= 1'b0;
         lts_protect_out    <= 1'b0;
      end else begin
         dcdc_force_off_out <= pwr_en_q[PWR_DCDC_OFF_BIT] || force_link;
         lts_charge_en_out  <= !primary;
         stores_connect_out <= force_link ||
                               (state_d == LINK_HOLD);
         sleep_request_out  <= pwr_en_q[PWR_SLEEP_BIT];
         lts_protect_out    <= protect;
      end
   end

   // ------------------------------------------------------------------
   // read-back; reserved and unmapped bits read zero
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         unique case (reg_addr_in)
            STORAGE_CELL_CONFIG_ADDR: reg_rdata_out <= 8'(cell_cfg_q);
            AUX_SUPPLY_CONFIG_ADDR:   reg_rdata_out <= 8'(aux_behav_q);
            AUX_GROUND_CONFIG_ADDR:   reg_rdata_out <= 8'(gnd_auto_q);
            POWER_SWITCH_ENABLE_ADDR: reg_rdata_out <= pwr_en_q;
            SWITCH_STATUS_ADDR: begin
               reg_rdata_out <= 8'h00;
               reg_rdata_out[STAT_PROTECT_BIT]   <= lts_protect_out;
               reg_rdata_out[STAT_CONNECTED_BIT] <= stores_connect_out;
            end
            default:                  reg_rdata_out <= 8'h00;
         endcase
      end
   end

endmodule

/* File: common/switch_ctrl_pkg.sv */
/*
 * constants for the storage and power switch control block: register
 * offsets, field positions, supply behaviour codes and timing counts.
 * assumes a 100 MHz system clock.
 */
package switch_ctrl_pkg;

   // ------------------------------------------------------------------
   // register offsets (byte-wide registers)
   // ------------------------------------------------------------------
   localparam logic [7:0] STORAGE_CELL_CONFIG_ADDR = 8'h06;
   localparam logic [7:0] AUX_SUPPLY_CONFIG_ADDR   = 8'h10;
   localparam logic [7:0] AUX_GROUND_CONFIG_ADDR   = 8'h11;
   localparam logic [7:0] POWER_SWITCH_ENABLE_ADDR = 8'h19;
   localparam logic [7:0] SWITCH_STATUS_ADDR       = 8'h1f;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CELL_NO_PROTECT_BIT   = 0;
   localparam int CELL_PRIMARY_BIT      = 1;
   localparam int CELL_FORCE_CONN_BIT   = 2;
   localparam int CELL_FIELD_WIDTH      = 3;
   localparam int GND_AUTO_LSB          = 0;
   localparam int AUX_CHANNELS          = 3;
   localparam int PWR_SLEEP_BIT         = 0;
   localparam int PWR_SUPPLY_EN_LSB     = 1;
   localparam int PWR_GROUND_EN_LSB     = 4;
   localparam int PWR_DCDC_OFF_BIT      = 7;
   localparam int AUX_BEHAV_WIDTH       = 2;
   localparam int STAT_PROTECT_BIT      = 0;
   localparam int STAT_CONNECTED_BIT    = 1;

   // reset values held until the nonvolatile defaults are loaded
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;

   // ------------------------------------------------------------------
   // auxiliary supply behaviour codes
   // ------------------------------------------------------------------
   localparam logic [1:0] AUX_ON_STORE    = 2'h0;
   localparam logic [1:0] AUX_ON_LDO      = 2'h1;
   localparam logic [1:0] AUX_AUTO_FLOAT  = 2'h2;
   localparam logic [1:0] AUX_AUTO_GROUND = 2'h3;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_FREQ_HZ       = 100_000_000;
   localparam int CONFIRM_TIME_US   = 1000;
   localparam int CONFIRM_CYCLES    = CLK_FREQ_HZ / 1_000_000 * CONFIRM_TIME_US;
   localparam int HOLD_HRV_PERIODS  = 2;

   typedef enum logic [1:0] {
      LINK_IDLE    = 2'b00,
      LINK_CONFIRM = 2'b01,
      LINK_HOLD    = 2'b10
   } link_state_t;

endpackage

/* File: dv/switch_control_props.sv */
/* checker for storage_switch_control, bound to the top module's ports.
   assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/100ps
module switch_control_props
   import switch_ctrl_pkg::*;
#(
   parameter int CONFIRM_COUNT = CONFIRM_CYCLES
) (
   input wire logic                    sys_clk_in,
   input wire logic                    srst_in,
   input wire logic [7:0]              reg_addr_in,
   input wire logic [7:0]              reg_wdata_in,
   input wire logic                    reg_wr_in,
   input wire logic [7:0]              reg_rdata_out,
   input wire logic                    sts_above_min_hi_in,
   input wire logic                    bat_below_min_lo_in,
   input wire logic                    hrv_period_in,
   input wire logic                    sleep_done_in,
   input wire logic [AUX_CHANNELS-1:0] aux_ground_close_out,
   input wire logic [AUX_CHANNELS-1:0] aux_to_store_out,
   input wire logic [AUX_CHANNELS-1:0] aux_to_ldo_out,
   input wire logic                    dcdc_force_off_out,
   input wire logic                    stores_connect_out,
   input wire logic                    sleep_request_out,
   input wire logic                    lts_protect_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   // levels pass two sync flops and the output register: three cycles
   chk_ground_gate: assert property (aux_ground_close_out != 3'h0 |->
      $past(sts_above_min_hi_in, 3)) else $error("ground closed below level");
   chk_supply_gate: assert property ((aux_to_store_out | aux_to_ldo_out) != 3'h0 |->
      $past(sts_above_min_hi_in, 3)) else $error("supply on below level");
   chk_protect_src: assert property (lts_protect_out |->
      $past(bat_below_min_lo_in, 3)) else $error("protect without low battery");
   chk_lowbat_apart: assert property (lts_protect_out |-> !stores_connect_out)
      else $error("stores linked while protected");
   chk_force_link: assert property (reg_wr_in && reg_addr_in == 8'h06 &&
      reg_wdata_in[2:0] == 3'h7 |-> ##2 dcdc_force_off_out && stores_connect_out)
      else $error("forced link missing");
   chk_sleep_set: assert property (reg_wr_in && reg_addr_in == 8'h19 ##1
      !sleep_done_in |-> ##1 sleep_request_out == $past(reg_wdata_in[0], 2))
      else $error("sleep request wrong");
   chk_sleep_clear: assert property (sleep_request_out && sleep_done_in &&
      !reg_wr_in |-> ##2 !sleep_request_out) else $error("sleep not ended");
   chk_read_back: assert property (reg_wr_in && reg_addr_in == 8'h19 ##1
      (reg_addr_in == 8'h19 && !reg_wr_in && !sleep_done_in) |=>
      reg_rdata_out == $past(reg_wdata_in, 2)) else $error("read back wrong");
   chk_reserved_zero: assert property (reg_addr_in == 8'h11 |=>
      reg_rdata_out[7:3] == 5'h00) else $error("reserved bits set");
   chk_link_hold: assert property ($rose(stores_connect_out) ##0 (!hrv_period_in &&
      !reg_wr_in && !bat_below_min_lo_in)[*4] |=> stores_connect_out)
      else $error("link dropped early");
endmodule

/* File: dv/comparator_model.sv */
/* far-side model: comparator levels, measurement and harvester period
   pulses, sleep interval timer. assumes the bench clock. */
`timescale 1ns/100ps
module comparator_model #(
   parameter int HRV_CYCLES   = 60,
   parameter int MEAS_CYCLES  = 30,
   parameter int SLEEP_CYCLES = 50
) (
   // clock and commanded analog state
   input  wire logic       sys_clk_in,
   input  wire logic [5:0] level_in,
   input  wire logic       sleep_request_in,
   // comparator and timer results
   output logic [5:0]      level_out,
   output logic            meas_done_out,
   output logic            hrv_period_out,
   output logic            sleep_done_out
);
   int hrv_cnt = 0;
   int meas_cnt = 0;
   int slp_cnt = 0;
   // comparators follow the analog levels at once
   assign level_out = level_in;
   initial begin
      meas_done_out = 1'b0;
      hrv_period_out = 1'b0;
      sleep_done_out = 1'b0;
   end
   always @(posedge sys_clk_in) begin
      hrv_cnt <= (hrv_cnt == HRV_CYCLES - 1) ? 0 : hrv_cnt + 1;
      hrv_period_out <= (hrv_cnt == HRV_CYCLES - 1);
      meas_cnt <= (meas_cnt == MEAS_CYCLES - 1) ? 0 : meas_cnt + 1;
      meas_done_out <= (meas_cnt == MEAS_CYCLES - 1);
      slp_cnt <= (sleep_request_in && !sleep_done_out) ? slp_cnt + 1 : 0;
      sleep_done_out <= (slp_cnt == SLEEP_CYCLES - 1);
   end
endmodule

/* File: dv/test_storage_switch_control.sv */
/* self-checking bench for storage_switch_control with the comparator model.
   assumes the design package is compiled first. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_storage_switch_control;
   import switch_ctrl_pkg::*;
   typedef struct {int due; int sel; logic [7:0] val;} note_t;
   logic       sys_clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, d;
   logic [2:0] aux_ground_close_out, aux_to_store_out, aux_to_ldo_out, aux_grounded_out;
   logic       dcdc_force_off_out, lts_charge_en_out, stores_connect_out;
   logic       sleep_request_out, lts_protect_out, meas, hrv, sdone;
   logic [5:0] lvl = 6'b111000, cmp;
   int         bad_count = 0, n_tests = 0, cyc = 0, seed = 27924, code;
   note_t      q[$];
   initial forever #5 sys_clk_in = ~sys_clk_in;
   storage_switch_control #(.CONFIRM_COUNT(20)) i_dut (.sys_clk_in, .srst_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out,
      .nvm_storage_cell_in(8'hf9), .nvm_aux_supply_in(8'hc6),
      .nvm_aux_ground_in(8'hfd), .nvm_power_switch_in(8'h0e),
      .sts_above_min_hi_in(cmp[5]), .sts_above_min_in(cmp[4]),
      .sts_below_apl_max_in(cmp[3]), .sts_below_disconnect_in(cmp[2]),
      .bat_below_min_lo_in(cmp[1]), .harvester_low_in(cmp[0]),
      .sts_meas_done_in(meas), .hrv_period_in(hrv), .sleep_done_in(sdone),
      .aux_ground_close_out, .aux_to_store_out, .aux_to_ldo_out,
      .aux_grounded_out, .dcdc_force_off_out, .lts_charge_en_out,
      .stores_connect_out, .sleep_request_out, .lts_protect_out);
   comparator_model i_model (.sys_clk_in, .level_in(lvl),
      .sleep_request_in(sleep_request_out), .level_out(cmp),
      .meas_done_out(meas), .hrv_period_out(hrv), .sleep_done_out(sdone));
   // ---------------------------------------------------------------
   // result watcher: compares due notes at the falling edge
   // ---------------------------------------------------------------
   always @(negedge sys_clk_in) begin
      logic [7:0] got;
      logic [4:0] bits;
      bits = {lts_protect_out, sleep_request_out, stores_connect_out,
              lts_charge_en_out, dcdc_force_off_out};
      while (q.size() > 0 && q[0].due <= cyc) begin
         case (q[0].sel)
            0: got = reg_rdata_out;
            1: got = {5'h00, aux_ground_close_out};
            2: got = {5'h00, aux_to_store_out};
            3: got = {5'h00, aux_to_ldo_out};
            4: got = {5'h00, aux_grounded_out};
            default: got = {7'h00, bits[q[0].sel - 5]};
         endcase
         `CHK(got, q[0].val)
         void'(q.pop_front());
      end
      cyc++;
   end
   task automatic note(input int sel, input logic [7:0] val, input int lat);
      q.push_back('{cyc + lat, sel, val});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      note(0, e, 1);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
   initial begin
      tick(5);
      srst_in <= 1'b0;
      tick(3);
      rd(8'h06, 8'h01);
      rd(8'h10, 8'h06);
      rd(8'h11, 8'h05);
      rd(8'h19, 8'h0e);
      wr(8'h00, 8'h55);
      rd(8'h00, 8'h00);
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed)) & 8'hfe;
         wr(8'h19, d);
         rd(8'h19, d);
      end
      wr(8'h11, 8'h00);
      for (code = 0; code < 4; code++) begin
         wr(8'h10, {2'b00, code[1:0], code[1:0], code[1:0]});
         wr(8'h19, 8'h0a);
         tick(5);
         note(2, (code == 1) ? 8'h00 : 8'h05, 0);
         note(3, (code == 1) ? 8'h05 : 8'h00, 0);
         note(4, (code == 3) ? 8'h02 : 8'h00, 0);
      end
      lvl <= 6'b011000;
      tick(5);
      note(2, 8'h00, 0);
      note(4, 8'h07, 0);
      lvl <= 6'b111000;
      wr(8'h11, 8'h05);
      wr(8'h19, 8'h70);
      tick(5);
      note(1, 8'h07, 0);
      lvl <= 6'b110000;
      tick(5);
      note(1, 8'h02, 0);
      lvl <= 6'b011000;
      tick(5);
      note(1, 8'h00, 0);
      lvl <= 6'b111000;
      wr(8'h19, 8'h80);
      wr(8'h06, 8'h00);
      tick(3);
      note(5, 8'h01, 0);
      note(6, 8'h01, 0);
      wr(8'h19, 8'h00);
      wr(8'h06, 8'h02);
      lvl <= 6'b111001;
      tick(5);
      note(6, 8'h00, 0);
      note(7, 8'h01, 0);
      lvl <= 6'b111000;
      tick(140);
      note(7, 8'h00, 0);
      lvl <= 6'b111100;
      tick(60);
      note(7, 8'h01, 0);
      lvl <= 6'b111000;
      tick(140);
      note(7, 8'h00, 0);
      lvl <= 6'b111011;
      tick(5);
      note(9, 8'h01, 0);
      note(7, 8'h00, 0);
      rd(8'h1f, 8'h01);
      wr(8'h06, 8'h07); // forced link with protection disabled while the battery reads low
      tick(3);
      note(9, 8'h00, 0);
      note(5, 8'h01, 0);
      rd(8'h1f, 8'h02);
      wr(8'h06, 8'h06);
      tick(3);
      note(7, 8'h00, 0);
      note(5, 8'h00, 0);
      lvl <= 6'b111000;
      tick(5);
      note(7, 8'h01, 0);
      wr(8'h06, 8'h00);
      wr(8'h19, 8'h01);
      note(8, 8'h01, 1);
      tick(60);
      note(8, 8'h00, 0);
      rd(8'h19, 8'h00);
      tick(3);
      give_verdict();
   end
endmodule
bind storage_switch_control switch_control_props #(.CONFIRM_COUNT(CONFIRM_COUNT)) i_props (
   .sys_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out,
   .sts_above_min_hi_in, .bat_below_min_lo_in, .hrv_period_in, .sleep_done_in,
   .aux_ground_close_out, .aux_to_store_out, .aux_to_ldo_out, .dcdc_force_off_out,
   .stores_connect_out, .sleep_request_out, .lts_protect_out);
